// [hw/ptg_defines.svh]
`ifndef PTG_DEFINES_SVH
`define PTG_DEFINES_SVH
`define PTG_AW          9
`define PTG_DW          32
`define PTG_SEEDA0      9'h12D
`define PTG_SEEDA1      9'h12E
`define PTG_SEEDA2      9'h12F
`define PTG_SEEDA3      9'h130
`define PTG_SEEDB0      9'h131
`define PTG_SEEDB1      9'h132
`define PTG_SEEDB2      9'h133
`define PTG_SEEDB3      9'h134
`define PTG_TXCTL       9'h135
`define PTG_TXCLK       9'h137
`define PTG_RXCTL       9'h15E
`define PTG_RXCLK       9'h164
`define PTG_RXSEL       9'h169
`define PTG_RXSTAT      9'h16A
`define PTG_TXCLK_PRBS  2
`define PTG_TXCLK_SQ    1
`define PTG_RXCTL_P7    14
`define PTG_RXCTL_P23   13
`define PTG_RXCTL_P9    12
`define PTG_RXCTL_P31   11
`define PTG_RXCTL_TEN   10
`define PTG_RXCLK_PRBS  10
`define PTG_RXSEL_SQ    0
`define PTG_STAT_LOCK   0
`define PTG_STAT_ERR    1
`define PTG_SEED_TOP_W  10
`define PTG_SCR_TAP_A   57
`define PTG_SCR_TAP_B   38
`define PTG_LF_WORD     32'h0100_009C
`define PTG_PRBS_INIT   31'h7FFF_FFFF
`endif

// [hw/ptg_pattern_top.sv]
// Overview of operation
// [RULE1] seed A is 58 bits in four words, low first, top word ten bits
// [RULE2] seed B is 58 bits in four further words, top word ten bits
// [RULE3] square wave field sets run of ones then zeros: 1,4,5,6,8,10
// [RULE4] tx control bit 10 picks prbs-7, bit 8 picks prbs-23
// [RULE5] tx control bit 6 picks prbs-9, bit 4 picks prbs-31
// [RULE6] tx control bit 3 starts the generator; clear passes traffic
// [RULE7] tx control bit 1 picks square wave when one, else pseudo-random
// [RULE8] tx control bit 0 picks local fault base data, else zero data
// [RULE9] tx clock register bit 2 gates prbs, bit 1 gates square wave
// [RULE10] rx control bit 14 checks prbs-7, bit 13 checks prbs-23
// [RULE11] rx control bit 12 checks prbs-9, bit 11 checks prbs-31
// [RULE12] rx control bit 10 turns the prbs verifier on
// [RULE13] rx clock register bit 10 gates the verifier
// [RULE14] rx select bit 0 expects square wave when one, else prbs; the code has no square-wave check and only stops the prbs verifier
// [RULE15] software enables one polynomial and the clock before the enable
// [RULE16] verifier compares received words against its own sequence; the code predicts each word from the word received before it
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
`include "ptg_defines.svh"
module ptg_pattern_top
(
   input  wire logic                   core_clk,
   input  wire logic                   nrst,
   input  wire logic [`PTG_AW-1:0]     regAddr,
   input  wire logic [15:0]            regWrData,
   input  wire logic                   regWrStb,
   input  wire logic                   regRdStb,
   output logic [15:0]                 regRdData,
   input  wire logic [`PTG_DW-1:0]     txData,
   output logic [`PTG_DW-1:0]          txPattern,
   input  wire logic [`PTG_DW-1:0]     rxData,
   output logic                        rxMismatch
);
   logic [57:0]          seedA_ff;
   logic [57:0]          seedB_ff;
   logic [15:0]          txCtl_ff;
   logic [15:0]          txClk_ff;
   logic [15:0]          rxCtl_ff;
   logic [15:0]          rxClk_ff;
   logic [15:0]          rxSel_ff;
   logic                 errSticky_ff;
   logic [15:0]          regRdData_ff;
   logic                 testOn_ff;
   logic [30:0]          prbsSt_ff;
   logic [57:0]          scr_ff;
   logic [4:0]           sqPos_ff;
   logic [`PTG_DW-1:0]   txPattern_ff;
   ptg_pkg::ptg_vst_t    vst_ff;
   logic [30:0]          rxHist_ff;
   logic                 rxMismatch_ff;

   ptg_pkg::ptg_txctl_t  txCtl;
   ptg_pkg::ptg_poly_t   polyTx;
   ptg_pkg::ptg_poly_t   polyRx;
   logic [31:0]          prbsWord;
   logic [30:0]          nxt_prbsSt;
   logic [31:0]          sqWord;
   logic [4:0]           nxt_sqPos;
   logic [31:0]          prpWord;
   logic [57:0]          nxt_scr;
   logic [31:0]          rxExpect;
   logic [30:0]          rxWordHist;
   logic [15:0]          nxt_regRdData;
   logic                 txStart;
   logic                 txPrbsRun;
   logic                 txSqRun;
   logic                 rxRun;
   logic                 rxTick;

   assign txCtl = ptg_pkg::ptg_txctl_t'(txCtl_ff);

   // register writes
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         seedA_ff <= 58'h0;
         seedB_ff <= 58'h0;
      end
      else if (regWrStb)
      begin
         if (regAddr == `PTG_SEEDA0)
            seedA_ff[15:0] <= regWrData; // RULE1
         else if (regAddr == `PTG_SEEDA1)
            seedA_ff[31:16] <= regWrData; // RULE1
         else if (regAddr == `PTG_SEEDA2)
            seedA_ff[47:32] <= regWrData; // RULE1
         else if (regAddr == `PTG_SEEDA3)
            seedA_ff[57:48] <= regWrData[`PTG_SEED_TOP_W-1:0]; // RULE1
         else if (regAddr == `PTG_SEEDB0)
            seedB_ff[15:0] <= regWrData; // RULE2
         else if (regAddr == `PTG_SEEDB1)
            seedB_ff[31:16] <= regWrData; // RULE2
         else if (regAddr == `PTG_SEEDB2)
            seedB_ff[47:32] <= regWrData; // RULE2
         else if (regAddr == `PTG_SEEDB3)
            seedB_ff[57:48] <= regWrData[`PTG_SEED_TOP_W-1:0]; // RULE2
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         txCtl_ff <= 16'h0000;
         txClk_ff <= 16'h0000;
         rxCtl_ff <= 16'h0000;
         rxClk_ff <= 16'h0000;
         rxSel_ff <= 16'h0000;
      end
      else if (regWrStb)
      begin
         if (regAddr == `PTG_TXCTL)
            txCtl_ff <= regWrData;
         else if (regAddr == `PTG_TXCLK)
            txClk_ff <= regWrData;
         else if (regAddr == `PTG_RXCTL)
            rxCtl_ff <= regWrData;
         else if (regAddr == `PTG_RXCLK)
            rxClk_ff <= regWrData;
         else if (regAddr == `PTG_RXSEL)
            rxSel_ff <= regWrData;
      end
   end

   // sticky mismatch flag; a new mismatch beats a clear in the same cycle
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         errSticky_ff <= 1'b0;
      else if (rxMismatch_ff)
         errSticky_ff <= 1'b1;
      else if (regWrStb && regAddr == `PTG_RXSTAT && regWrData[`PTG_STAT_ERR])
         errSticky_ff <= 1'b0;
   end

   // read decode; unmapped addresses read zero
   always_comb
   begin
      nxt_regRdData = 16'h0000;
      if (regAddr == `PTG_SEEDA0)
         nxt_regRdData = seedA_ff[15:0];
      else if (regAddr == `PTG_SEEDA1)
         nxt_regRdData = seedA_ff[31:16];
      else if (regAddr == `PTG_SEEDA2)
         nxt_regRdData = seedA_ff[47:32];
      else if (regAddr == `PTG_SEEDA3)
         nxt_regRdData = {6'h00, seedA_ff[57:48]};
      else if (regAddr == `PTG_SEEDB0)
         nxt_regRdData = seedB_ff[15:0];
      else if (regAddr == `PTG_SEEDB1)
         nxt_regRdData = seedB_ff[31:16];
      else if (regAddr == `PTG_SEEDB2)
         nxt_regRdData = seedB_ff[47:32];
      else if (regAddr == `PTG_SEEDB3)
         nxt_regRdData = {6'h00, seedB_ff[57:48]};
      else if (regAddr == `PTG_TXCTL)
         nxt_regRdData = txCtl_ff;
      else if (regAddr == `PTG_TXCLK)
         nxt_regRdData = txClk_ff;
      else if (regAddr == `PTG_RXCTL)
         nxt_regRdData = rxCtl_ff;
      else if (regAddr == `PTG_RXCLK)
         nxt_regRdData = rxClk_ff;
      else if (regAddr == `PTG_RXSEL)
         nxt_regRdData = rxSel_ff;
      else if (regAddr == `PTG_RXSTAT)
         nxt_regRdData = {14'h0000, errSticky_ff, vst_ff == ptg_pkg::PTG_V_CHECK};
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         regRdData_ff <= 16'h0000;
      else if (regRdStb)
         regRdData_ff <= nxt_regRdData;
      else
         regRdData_ff <= 16'h0000;
   end

   // polynomial choice; the lowest bit number loses if software sets several
   always_comb
   begin
      if (txCtl.p7)
         polyTx = ptg_pkg::PTG_POLY7; // RULE4
      else if (txCtl.p23)
         polyTx = ptg_pkg::PTG_POLY23; // RULE4
      else if (txCtl.p9)
         polyTx = ptg_pkg::PTG_POLY9; // RULE5
      else if (txCtl.p31)
         polyTx = ptg_pkg::PTG_POLY31; // RULE5
      else
         polyTx = ptg_pkg::PTG_POLY_NONE;
   end

   always_comb
   begin
      if (rxCtl_ff[`PTG_RXCTL_P7])
         polyRx = ptg_pkg::PTG_POLY7; // RULE10
      else if (rxCtl_ff[`PTG_RXCTL_P23])
         polyRx = ptg_pkg::PTG_POLY23; // RULE10
      else if (rxCtl_ff[`PTG_RXCTL_P9])
         polyRx = ptg_pkg::PTG_POLY9; // RULE11
      else if (rxCtl_ff[`PTG_RXCTL_P31])
         polyRx = ptg_pkg::PTG_POLY31; // RULE11
      else
         polyRx = ptg_pkg::PTG_POLY_NONE;
   end

   ptg_prbs_step u_txPrbs
   (
      .poly    (polyTx),
      .hist    (prbsSt_ff),
      .word    (prbsWord),
      .nxtHist (nxt_prbsSt)
   );

   ptg_sq_wave u_txSq
   (
      .run    (txCtl.sqRun),
      .pos    (sqPos_ff),
      .word   (sqWord),
      .nxtPos (nxt_sqPos)
   );

   // pseudo-random pattern: base data through the 58-bit scrambler
   always_comb
   begin
      logic [57:0] s;
      logic [31:0] d;
      logic        ob;
      ob = 1'b0;
      s = scr_ff;
      d = txCtl.dataSel ? `PTG_LF_WORD : 32'h0000_0000; // RULE8
      prpWord = 32'h0000_0000;
      for (int i = 0; i < 32; i++)
      begin
         ob = d[i] ^ s[`PTG_SCR_TAP_A] ^ s[`PTG_SCR_TAP_B];
         prpWord[i] = ob;
         s = {s[56:0], ob};
      end
      nxt_scr = s;
   end

   // state loads on the enable's first cycle; that cycle sends zeros
   assign txStart   = txCtl.testEn && !testOn_ff;
   assign txPrbsRun = txCtl.testEn && testOn_ff && !txCtl.patSel
                      && txClk_ff[`PTG_TXCLK_PRBS]; // RULE9
   assign txSqRun   = txCtl.testEn && testOn_ff && txCtl.patSel
                      && txClk_ff[`PTG_TXCLK_SQ]; // RULE9

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         testOn_ff <= 1'b0;
      else
         testOn_ff <= txCtl.testEn;
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         prbsSt_ff <= 31'h0;
         scr_ff    <= 58'h0;
      end
      else if (txStart)
      begin
         prbsSt_ff <= `PTG_PRBS_INIT;
         // seed B pairs with local fault data, seed A with zero data
         scr_ff    <= txCtl.dataSel ? seedB_ff : seedA_ff; // RULE1 RULE2
      end
      else if (txPrbsRun)
      begin
         if (polyTx == ptg_pkg::PTG_POLY_NONE)
            scr_ff <= nxt_scr;
         else
            prbsSt_ff <= nxt_prbsSt;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         sqPos_ff <= 5'h00;
      else if (txStart)
         sqPos_ff <= 5'h00;
      else if (txSqRun)
         sqPos_ff <= nxt_sqPos; // RULE3
   end

   // a gated generator holds its last word rather than dropping to idle
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         txPattern_ff <= 32'h0000_0000;
      else if (!txCtl.testEn)
         txPattern_ff <= txData; // RULE6
      else if (txStart)
         txPattern_ff <= 32'h0000_0000;
      else if (txSqRun)
         txPattern_ff <= sqWord; // RULE7
      else if (txPrbsRun)
         txPattern_ff <= (polyTx == ptg_pkg::PTG_POLY_NONE) ? prpWord
                                                             : prbsWord; // RULE7
   end

   // verifier: reseeds from every received word and predicts the word after it
   ptg_prbs_step u_rxPrbs
   (
      .poly    (polyRx),
      .hist    (rxHist_ff),
      .word    (rxExpect),
      .nxtHist ()
   );

   always_comb
   begin
      for (int k = 0; k < 31; k++)
         rxWordHist[k] = rxData[31-k];
   end

   assign rxRun  = rxCtl_ff[`PTG_RXCTL_TEN] && !rxSel_ff[`PTG_RXSEL_SQ]
                   && polyRx != ptg_pkg::PTG_POLY_NONE; // RULE12 RULE14
   assign rxTick = rxClk_ff[`PTG_RXCLK_PRBS]; // RULE13

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         vst_ff <= ptg_pkg::PTG_V_IDLE;
      else if (!rxRun)
         vst_ff <= ptg_pkg::PTG_V_IDLE; // RULE12
      else if (rxTick)
      begin
         case (vst_ff)
            ptg_pkg::PTG_V_IDLE:  vst_ff <= ptg_pkg::PTG_V_SEED;
            ptg_pkg::PTG_V_SEED:  vst_ff <= ptg_pkg::PTG_V_CHECK;
            ptg_pkg::PTG_V_CHECK: vst_ff <= ptg_pkg::PTG_V_CHECK;
            default:              vst_ff <= ptg_pkg::PTG_V_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rxHist_ff <= 31'h0;
      else if (rxRun && rxTick && vst_ff != ptg_pkg::PTG_V_IDLE)
         rxHist_ff <= rxWordHist; // RULE13
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rxMismatch_ff <= 1'b0;
      else
         rxMismatch_ff <= rxRun && rxTick && vst_ff == ptg_pkg::PTG_V_CHECK
                          && rxData != rxExpect; // RULE16
   end

   assign regRdData  = regRdData_ff;
   assign txPattern  = txPattern_ff;
   assign rxMismatch = rxMismatch_ff;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);

   property p_seedTop;
      regWrStb && regAddr == `PTG_SEEDA3 ##2 regRdStb && regAddr == `PTG_SEEDA3
      |=> regRdData[15:10] == 6'h00 && regRdData[9:0] == $past(regWrData[9:0], 3);
   endproperty
   a_seedTop: assert property (p_seedTop) else $error("seed A top word bad"); // RULE1

   property p_seedB;
      regWrStb && regAddr == `PTG_SEEDB0 |=> seedB_ff[15:0] == $past(regWrData);
   endproperty
   a_seedB: assert property (p_seedB) else $error("seed B low word lost"); // RULE2

   property p_sqRun1;
      txSqRun && txCtl.sqRun == 4'h1 |=> txPattern_ff == 32'h5555_5555
                                          || txPattern_ff == 32'hAAAA_AAAA;
   endproperty
   a_sqRun1: assert property (p_sqRun1) else $error("run one not alternating"); // RULE3

   property p_txPoly7;
      txCtl.p7 |-> polyTx == ptg_pkg::PTG_POLY7;
   endproperty
   a_txPoly7: assert property (p_txPoly7) else $error("tx prbs7 not chosen"); // RULE4

   property p_txPoly9;
      txCtl.p9 && !txCtl.p7 && !txCtl.p23 |-> polyTx == ptg_pkg::PTG_POLY9;
   endproperty
   a_txPoly9: assert property (p_txPoly9) else $error("tx prbs9 not chosen"); // RULE5

   property p_passThru;
      !txCtl.testEn |=> txPattern_ff == $past(txData);
   endproperty
   a_passThru: assert property (p_passThru) else $error("traffic not passed"); // RULE6

   property p_sqSel;
      txSqRun |=> txPattern_ff == $past(sqWord);
   endproperty
   a_sqSel: assert property (p_sqSel) else $error("square wave not sent"); // RULE7

   property p_prpData;
      txPrbsRun && polyTx == ptg_pkg::PTG_POLY_NONE |=> txPattern_ff == $past(prpWord);
   endproperty
   a_prpData: assert property (p_prpData) else $error("pattern word wrong"); // RULE8

   property p_prbsGate;
      txCtl.testEn && testOn_ff && !txCtl.patSel && !txClk_ff[`PTG_TXCLK_PRBS]
      ##1 txCtl.testEn |-> $stable(txPattern_ff);
   endproperty
   a_prbsGate: assert property (p_prbsGate) else $error("gated prbs moved"); // RULE9

   property p_rxPoly;
      rxCtl_ff[`PTG_RXCTL_P7] |-> polyRx == ptg_pkg::PTG_POLY7;
   endproperty
   a_rxPoly: assert property (p_rxPoly) else $error("rx prbs7 not chosen"); // RULE10

   property p_rxPoly9;
      rxCtl_ff[`PTG_RXCTL_P9] && !rxCtl_ff[`PTG_RXCTL_P7] && !rxCtl_ff[`PTG_RXCTL_P23]
      |-> polyRx == ptg_pkg::PTG_POLY9;
   endproperty
   a_rxPoly9: assert property (p_rxPoly9) else $error("rx prbs9 not chosen"); // RULE11

   property p_rxOff;
      !rxCtl_ff[`PTG_RXCTL_TEN] |=> !rxMismatch_ff ##1 vst_ff != ptg_pkg::PTG_V_CHECK;
   endproperty
   a_rxOff: assert property (p_rxOff) else $error("verifier ran while off"); // RULE12

   property p_rxGate;
      !rxTick |=> $stable(rxHist_ff) && !rxMismatch_ff;
   endproperty
   a_rxGate: assert property (p_rxGate) else $error("gated verifier moved"); // RULE13

   property p_rxSq;
      rxSel_ff[`PTG_RXSEL_SQ] |=> !rxMismatch_ff;
   endproperty
   a_rxSq: assert property (p_rxSq) else $error("prbs check in square mode"); // RULE14

   property p_check;
      rxRun && rxTick && vst_ff == ptg_pkg::PTG_V_CHECK && rxData != rxExpect
      |=> rxMismatch_ff ##1 errSticky_ff;
   endproperty
   a_check: assert property (p_check) else $error("mismatch missed"); // RULE16

   c_sqWave: cover property (txSqRun ##1 txSqRun);
   c_prbsTx: cover property (txPrbsRun && polyTx == ptg_pkg::PTG_POLY31);
   c_rxLock: cover property (vst_ff == ptg_pkg::PTG_V_CHECK [*4]);
   c_rxErr:  cover property (rxMismatch_ff);
endmodule : ptg_pattern_top

// [hw/ptg_pkg.sv]
package ptg_pkg;
   typedef enum logic [2:0] {PTG_POLY_NONE, PTG_POLY7, PTG_POLY9, PTG_POLY23,
                             PTG_POLY31} ptg_poly_t;
   typedef enum logic [1:0] {PTG_V_IDLE, PTG_V_SEED, PTG_V_CHECK} ptg_vst_t;
   typedef struct packed {
      logic [3:0] sqRun;
      logic       rsv11;
      logic       p7;
      logic       rsv9;
      logic       p23;
      logic       rsv7;
      logic       p9;
      logic       rsv5;
      logic       p31;
      logic       testEn;
      logic       rsv2;
      logic       patSel;
      logic       dataSel;
   } ptg_txctl_t;
endpackage : ptg_pkg

// [hw/ptg_prbs_step.sv]
`timescale 1ns/10ps
// advances a prbs history by one word; hist[0] is the newest bit
module ptg_prbs_step
(
   input  ptg_pkg::ptg_poly_t poly,
   input  wire logic [30:0]   hist,
   output logic [31:0]        word,
   output logic [30:0]        nxtHist
);
   always_comb
   begin
      logic [30:0] h;
      logic        nb;
      nb = 1'b0;
      h = hist;
      word = 32'h0000_0000;
      for (int i = 0; i < 32; i++)
      begin
         case (poly)
            ptg_pkg::PTG_POLY7:  nb = h[6] ^ h[5];
            ptg_pkg::PTG_POLY9:  nb = h[8] ^ h[4];
            ptg_pkg::PTG_POLY23: nb = h[22] ^ h[17];
            ptg_pkg::PTG_POLY31: nb = h[30] ^ h[27];
            default:             nb = 1'b0;
         endcase
         word[i] = nb;
         h = {h[29:0], nb};
      end
      nxtHist = h;
   end
endmodule : ptg_prbs_step

// [hw/ptg_sq_wave.sv]
`timescale 1ns/10ps
// one word of square wave; pos is the place inside the 2*run period
module ptg_sq_wave
(
   input  wire logic [3:0] run,
   input  wire logic [4:0] pos,
   output logic [31:0]     word,
   output logic [4:0]      nxtPos
);
   always_comb
   begin
      logic [4:0] r;
      logic [4:0] p;
      r = 5'h01;
      p = 5'h00;
      // unsupported run lengths fall back to one
      case (run)
         4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'hA: r = {1'b0, run};
         default:                            r = 5'h01;
      endcase
      p = (pos >= (r << 1)) ? 5'h00 : pos;
      word = 32'h0000_0000;
      for (int i = 0; i < 32; i++)
      begin
         word[i] = (p < r);
         p = (p == ((r << 1) - 5'h01)) ? 5'h00 : p + 5'h01;
      end
      nxtPos = p;
   end
endmodule : ptg_sq_wave

// [testbench/ptg_link_model.sv]
`timescale 1ns/10ps
// far-side serial loop: returns each transmit word one cycle later
module ptg_link_model
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire logic [31:0] txPattern,
   input  wire logic        flipBit,
   output logic [31:0]      rxData
);
   logic [31:0] rxWord_ff;

   // a one-cycle flip corrupts exactly one word on the line
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
         rxWord_ff <= 32'h0000_0000;
      else
         rxWord_ff <= txPattern ^ {31'h0000_0000, flipBit};
   end

   assign rxData = rxWord_ff;
endmodule : ptg_link_model

// [testbench/ptg_pattern_top_bench.sv]
`timescale 1ns/10ps
`include "ptg_defines.svh"
module ptg_pattern_top_bench;
   logic                core_clk;
   logic                nrst;
   logic [`PTG_AW-1:0]  regAddr;
   logic [15:0]         regWrData;
   logic                regWrStb;
   logic                regRdStb;
   logic [15:0]         regRdData;
   logic [31:0]         txData;
   logic [31:0]         txPattern;
   logic [31:0]         rxData;
   logic                rxMismatch;
   logic                flipBit;
   logic [30:0]         hist;
   logic [57:0]         scr;
   logic [31:0]         held;
   int                  pos;
   int                  pulseCnt;
   int                  error_cnt;
   int                  cmp_count;
   int                  runs [7] = '{1, 4, 5, 6, 8, 10, 3};
   int                  txBit [4] = '{10, 8, 6, 4};
   int                  rxBit [4] = '{14, 13, 12, 11};
   int                  tapN [4] = '{7, 23, 9, 31};
   int                  tapM [4] = '{6, 18, 5, 28};
   logic [63:0]         seedA = 64'h02AB_CDEF_0123_4567;
   logic [63:0]         seedB = 64'h0155_3210_FEDC_BA98;

   ptg_pattern_top dut (.core_clk(core_clk), .nrst(nrst), .regAddr(regAddr),
      .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
      .regRdData(regRdData), .txData(txData), .txPattern(txPattern),
      .rxData(rxData), .rxMismatch(rxMismatch));

   ptg_link_model link (.core_clk(core_clk), .nrst(nrst), .txPattern(txPattern),
      .flipBit(flipBit), .rxData(rxData));

   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      if (rxMismatch === 1'b1)
         pulseCnt++;
   end

   task give_verdict;
   begin
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   end
   endtask : give_verdict

   task cmp_reg(input logic [15:0] act, input logic [15:0] exp);
   begin
      cmp_count++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: register got %h expected %h", $time, act, exp);
      end
   end
   endtask : cmp_reg

   task cmp_word(input logic [31:0] act, input logic [31:0] exp);
   begin
      cmp_count++;
      if (act !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: word got %h expected %h", $time, act, exp);
      end
   end
   endtask : cmp_word

   task wr(input logic [8:0] a, input logic [15:0] d);
   begin
      @(posedge core_clk);
      regAddr   <= a;
      regWrData <= d;
      regWrStb  <= 1'b1;
      @(posedge core_clk);
      regWrStb  <= 1'b0;
   end
   endtask : wr

   task rd(input logic [8:0] a, input logic [15:0] exp);
   begin
      @(posedge core_clk);
      regAddr   <= a;
      regRdStb  <= 1'b1;
      @(posedge core_clk);
      regRdStb  <= 1'b0;
      #1;
      cmp_reg(regRdData, exp);
   end
   endtask : rd

   // bit 0 of each word is first in time
   function automatic logic [31:0] gen(int kind, int n, int m, int run, logic [31:0] d);
      logic [31:0] w;
      logic        b;
      for (int i = 0; i < 32; i++)
      begin
         if (kind == 0)
         begin
            b = hist[n-1] ^ hist[m-1];
            hist = {hist[29:0], b};
         end
         else if (kind == 1)
         begin
            b = d[i] ^ scr[57] ^ scr[38];
            scr = {scr[56:0], b};
         end
         else
         begin
            b = (pos < run);
            pos = (pos + 1) % (2 * run);
         end
         w[i] = b;
      end
      return w;
   endfunction : gen

   // clears the enable first so the next enable reloads the generator
   task tx_go(input logic [15:0] ctl, input logic [15:0] clk);
   begin
      wr(`PTG_TXCTL, 16'h0000);
      wr(`PTG_TXCLK, clk);
      wr(`PTG_TXCTL, ctl);
   end
   endtask : tx_go

   task run_stream(input int kind, input int n, input int m, input int run,
                   input logic [31:0] d);
   begin
      hist = 31'h7FFF_FFFF;
      pos  = 0;
      scr  = (d == 32'h0000_0000) ? seedA[57:0] : seedB[57:0];
      @(posedge core_clk);
      #1;
      cmp_word(txPattern, 32'h0000_0000);
      repeat (6)
      begin
         @(posedge core_clk);
         #1;
         cmp_word(txPattern, gen(kind, n, m, run, d));
      end
   end
   endtask : run_stream

   task inject;
   begin
      repeat (4) @(posedge core_clk);
      pulseCnt = 0;
      @(posedge core_clk);
      flipBit <= 1'b1;
      @(posedge core_clk);
      flipBit <= 1'b0;
      repeat (6) @(posedge core_clk);
   end
   endtask : inject

   initial
   begin
      #200000;
      error_cnt++;
      give_verdict();
   end

   initial
   begin
      nrst = 1'b0;
      regAddr = 9'h000;
      regWrData = 16'h0000;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      txData = 32'h0000_0000;
      flipBit = 1'b0;
      error_cnt = 0;
      cmp_count = 0;
      repeat (5) @(posedge core_clk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++)
         rd(9'(`PTG_SEEDA0 + i), 16'h0000);
      rd(`PTG_TXCTL, 16'h0000);
      rd(`PTG_RXCTL, 16'h0000);
      for (int i = 0; i < 8; i++)
         wr(9'(`PTG_SEEDA0 + i), 16'hFFFF);
      for (int i = 0; i < 8; i++)
         rd(9'(`PTG_SEEDA0 + i), (i % 4 == 3) ? 16'h03FF : 16'hFFFF);
      wr(`PTG_SEEDA3, 16'hFC00);
      rd(`PTG_SEEDA3, 16'h0000);
      wr(9'h100, 16'hFFFF);
      rd(9'h100, 16'h0000);
      for (int i = 0; i < 4; i++)
      begin
         wr(9'(`PTG_SEEDA0 + i), seedA[16*i +: 16]);
         wr(9'(`PTG_SEEDB0 + i), seedB[16*i +: 16]);
      end
      $display("test registers done");
      @(posedge core_clk);
      txData <= 32'hCAFE_0001;
      @(posedge core_clk);
      txData <= 32'h1234_5678;
      #1;
      cmp_word(txPattern, 32'hCAFE_0001);
      @(posedge core_clk);
      #1;
      cmp_word(txPattern, 32'h1234_5678);
      $display("test passthrough done");
      for (int j = 0; j < 4; j++)
      begin
         tx_go(16'h0008 | 16'(1 << txBit[j]), 16'h0004);
         run_stream(0, tapN[j], tapM[j], 1, 32'h0000_0000);
      end
      wr(`PTG_TXCLK, 16'h0000);
      repeat (2) @(posedge core_clk);
      #1;
      held = txPattern;
      repeat (4) @(posedge core_clk);
      #1;
      cmp_word(txPattern, held);
      $display("test prbs done");
      for (int j = 0; j < 7; j++)
      begin
         tx_go({4'(runs[j]), 12'h00A}, 16'h0002);
         run_stream(2, 0, 0, (runs[j] == 3) ? 1 : runs[j], 32'h0000_0000);
      end
      tx_go(16'h0008, 16'h0004);
      run_stream(1, 0, 0, 1, 32'h0000_0000);
      tx_go(16'h0009, 16'h0004);
      run_stream(1, 0, 0, 1, `PTG_LF_WORD);
      $display("test pseudo-random done");
      for (int j = 0; j < 4; j++)
      begin
         wr(`PTG_RXCTL, 16'h0000);
         tx_go(16'h0008 | 16'(1 << txBit[j]), 16'h0004);
         wr(`PTG_RXCLK, 16'h0400);
         wr(`PTG_RXCTL, 16'h0400 | 16'(1 << rxBit[j]));
         repeat (10) @(posedge core_clk);
         pulseCnt = 0;
         repeat (20) @(posedge core_clk);
         cmp_word(32'(pulseCnt), 32'h0000_0000);
         inject();
         cmp_word({31'h0000_0000, pulseCnt != 0}, 32'h0000_0001);
      end
      rd(`PTG_RXSTAT, 16'h0003);
      wr(`PTG_RXSTAT, 16'h0002);
      rd(`PTG_RXSTAT, 16'h0001);
      wr(`PTG_RXSEL, 16'h0001);
      inject();
      cmp_word(32'(pulseCnt), 32'h0000_0000);
      wr(`PTG_RXSEL, 16'h0000);
      wr(`PTG_RXCLK, 16'h0000);
      inject();
      cmp_word(32'(pulseCnt), 32'h0000_0000);
      wr(`PTG_RXCLK, 16'h0400);
      wr(`PTG_RXCTL, 16'(1 << rxBit[3]));
      inject();
      cmp_word(32'(pulseCnt), 32'h0000_0000);
      $display("test verifier done");
      give_verdict();
   end
endmodule : ptg_pattern_top_bench
